// ===== host_model.sv
// Purpose: I2C bus master standing in for the host controller
// Assumes: both lines resolved outside with pull-ups
// Notes:   drives change only after mclk falls
`default_nettype none
module host_model #(
  parameter int H = 12
) (
  input  wire logic mclk,
  input  wire logic scl_w,
  input  wire logic sda_w,
  output logic      scl_m,
  output logic      sda_m
);
  timeunit 1ns;
  timeprecision 100ps;
  int stalls = 0;
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // target may hold the clock low, so wait for the wire
  task automatic rise();
    int k;
    k = 0;
    scl_m = 1'b1;
    while (scl_w !== 1'b1 && k < 200) begin
      hw(1);
      k++;
    end
    if (scl_w !== 1'b1) stalls++;
  endtask
  task automatic start();
    hw(2);
    sda_m = 1'b1;
    hw(H);
    rise();
    hw(H);
    sda_m = 1'b0;
    hw(H);
    scl_m = 1'b0;
  endtask
  task automatic stop();
    hw(2);
    sda_m = 1'b0;
    hw(H);
    rise();
    hw(H);
    sda_m = 1'b1;
    hw(H);
  endtask
  // data moves two cycles after the fall: no false start or stop
  task automatic bit_io(input logic b, output logic s);
    hw(2);
    sda_m = b;
    hw(H);
    rise();
    hw(H / 2);
    s = sda_w;
    hw(H / 2);
    scl_m = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ackb, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(ackb, s);
    ack = !s;
  endtask
endmodule // host_model
`default_nettype wire

// ===== tag_defs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: system clock of 40 MHz
// Notes:   register data is a 16-bit word, high byte at the even address
`ifndef TAG_DEFS_SVH
`define TAG_DEFS_SVH
`define TGT_ADDR_HI  4'h3
`define REG_STATUS   16'hFFFC
`define REG_CONTROL  16'hFFFE
`define REG_KEY      16'hFFE0
`define REG_RATE     16'h2ABA
`define REG_ARM      16'h27B8
`define SEQ1_D0      8'h4E
`define SEQ2_D0      8'h80
`define CTL_RST      16'h0000
`define CAP_RST      8'h00
`define STAT_UP      8'h01
`define CTL_RADIO    1
`define CTL_PAR_MODE 12
`define MCLK_MHZ     40
`define T_READY_NS   1000
`define T_STRETCH_NS 500
`define READY_CYC    8'(((`T_READY_NS * `MCLK_MHZ) + 999) / 1000)
`define STRETCH_CYC  8'(((`T_STRETCH_NS * `MCLK_MHZ) + 999) / 1000)
`endif

// ===== tag_host_serial_port.sv
// Purpose: I2C target port of the tag, control/status words, rate capability
// Assumes: scl, sda and address-select pins are asynchronous to mclk
// Notes:   open-drain pins split into level in, low drive and enable
// Behaviour
// - ready output is high whenever a new transaction can be taken.
// - ready drops during a transaction; host must not start while low.
// - after STOP, ready rises again following a short processing delay.
// - device may stretch SCL low while preparing read data; host waits.
// - with all select pins low the target address is 18h.
// - parity mode uses two address bytes, two data bytes, one parity byte.
// - write parity covers 16-bit address and 16-bit data, sent last.
// - a write with wrong parity is dropped, target stays unchanged.
// - the target address byte never enters the parity.
// - parity read returns two data bytes then parity over address and data.
// - contactless link may run at 106, 212, 424 and 848 kbps.
// - after power-up the advertised capability is 106 kbps only.
// - a reader selection asking a higher rate is still answered.
// - completing the sequence clears the control word to zero.
// - capability F7h written in step three advertises all rates.
// - writing 00h,16h to control word sets radio enable.
// - status word reads 00h,01h while the device is up.
// - target address is 0011b above the three select pins.
// - normal mode advances the address by one per data byte.
`default_nettype none
`include "tag_defs.svh"
module tag_host_serial_port
  import tag_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       addr_select_bit0,
  input  wire logic       addr_select_bit1,
  input  wire logic       addr_select_bit2,
  output logic            ready,
  output logic            radio_enable,
  output logic [7:0]      rate_cap,
  output logic            high_rate_answer
);

  port_state_t r, n;
  logic        scl, sda, rise, fall, start_ev, stop_ev, par_mode;

  // ------------------------------------------------------------
  // pin conditioning
  // ------------------------------------------------------------
  assign scl      = r.filt[0];
  assign sda      = r.filt[1];
  assign rise     = scl & ~r.pv[0];
  assign fall     = ~scl & r.pv[0];
  assign start_ev = scl & r.pv[0] & r.pv[1] & ~sda;
  assign stop_ev  = scl & r.pv[0] & ~r.pv[1] & sda;
  assign par_mode = r.ctl[`CTL_PAR_MODE];

  // ------------------------------------------------------------
  // register map access
  // ------------------------------------------------------------
  function automatic logic [15:0] put(input logic [15:0] c, input logic [15:0] a,
                                      input logic [7:0] b);
    logic [15:0] v;
    v = c;
    if (a == `REG_CONTROL) v[15:8] = b;
    if (a == `REG_CONTROL + 16'h1) v[7:0] = b;
    return v;
  endfunction

  function automatic logic [7:0] get(input port_state_t s, input logic [15:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == `REG_STATUS + 16'h1) v = s.up ? `STAT_UP : 8'h00;
    if (a == `REG_CONTROL) v = s.ctl[15:8];
    if (a == `REG_CONTROL + 16'h1) v = s.ctl[7:0];
    return v;
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] b;
    logic       ok;
    logic       hit;
    b   = 8'h00;
    ok  = 1'b0;
    hit = 1'b0;
    n   = r;
    // third stage only counts once the second agrees with it
    n.s1   = {addr_select_bit2, addr_select_bit1, addr_select_bit0, sda_i, scl_i};
    n.s2   = r.s1;
    n.s3   = r.s2;
    n.filt = (r.s2 & r.s3) | (r.filt & (r.s2 | r.s3));
    n.pv   = r.filt[1:0];
    n.up   = 1'b1;
    if (r.dly != 8'h0) begin
      n.dly = r.dly - 8'h1;
      if (r.dly == 8'h1) n.rdy = 1'b1;
    end
    unique case (r.st)
      S_IDLE: ;
      S_RXB: begin
        if (rise) begin
          n.sh   = {r.sh[6:0], sda};
          n.bitn = r.bitn + 4'h1;
        end else if (fall && r.bitn == 4'h8) begin
          n.bitn   = 4'h0;
          n.idx    = (r.idx == 3'h7) ? 3'h7 : r.idx + 3'h1;
          n.st     = S_ACK;
          n.sda_oe = 1'b1;
          case (r.idx)
            3'h0: begin
              if (r.sh[7:1] != {`TGT_ADDR_HI, r.filt[4:2]}) begin
                n.st     = S_IDLE;
                n.sda_oe = 1'b0;
              end
              n.rd = r.sh[0];
            end
            3'h1: begin
              n.ad[15:8]  = r.sh;
              n.ptr[15:8] = r.sh;
              n.par       = r.sh;
            end
            3'h2: begin
              n.ad[7:0]  = r.sh;
              n.ptr[7:0] = r.sh;
              n.par      = r.par ^ r.sh;
            end
            default: begin
              n.par = r.par ^ r.sh;
              if (r.idx == 3'h3) n.d0 = r.sh;
              if (r.idx == 3'h4) n.d1 = r.sh;
              if (!par_mode) begin
                n.ctl = put(r.ctl, r.ptr, r.sh);
                n.ptr = r.ptr + 16'h1;
              end else if (r.idx > 3'h5) begin
                n.sda_oe = 1'b0;
              end
            end
          endcase
        end
      end
      S_ACK: begin
        if (fall) begin
          n.sda_oe = 1'b0;
          if (r.rd) begin
            n.st     = S_PREP;
            n.cnt    = `STRETCH_CYC;
            n.scl_oe = 1'b1;
          end else begin
            n.st = S_RXB;
          end
        end
      end
      S_PREP: begin
        n.cnt = r.cnt - 8'h1;
        if (r.cnt == 8'h1) begin
          if (par_mode && r.idx == 3'h3) begin
            b = r.par;
          end else begin
            b     = get(r, r.ptr);
            n.ptr = r.ptr + 16'h1;
            n.par = r.par ^ b;
          end
          n.sh     = b;
          n.idx    = (r.idx == 3'h7) ? 3'h7 : r.idx + 3'h1;
          n.st     = S_TXB;
          n.scl_oe = 1'b0;
          n.sda_oe = ~b[7];
        end
      end
      S_TXB: begin
        if (fall) begin
          n.bitn = r.bitn + 4'h1;
          if (r.bitn == 4'h7) begin
            n.st     = S_RACK;
            n.sda_oe = 1'b0;
            n.bitn   = 4'h0;
          end else begin
            n.sh     = {r.sh[6:0], 1'b0};
            n.sda_oe = ~r.sh[6];
          end
        end
      end
      S_RACK: begin
        if (rise) begin
          n.ack = ~sda;
        end else if (fall) begin
          if (r.ack) begin
            n.st     = S_PREP;
            n.cnt    = `STRETCH_CYC;
            n.scl_oe = 1'b1;
          end else begin
            n.st = S_IDLE;
          end
        end
      end
    endcase
    if (start_ev) begin
      n.st     = S_RXB;
      n.bitn   = 4'h0;
      n.idx    = 3'h0;
      n.sda_oe = 1'b0;
      n.scl_oe = 1'b0;
      n.rdy    = 1'b0;
      n.dly    = 8'h0;
    end
    if (stop_ev) begin
      n.st     = S_IDLE;
      n.sda_oe = 1'b0;
      n.scl_oe = 1'b0;
      n.dly    = `READY_CYC;
      // parity commit and sequence step need at least two data bytes; normal mode writes each byte as it arrives
      if (!r.rd && r.idx >= 3'h5) begin
        ok = !par_mode || (r.idx == 3'h6 && r.par == 8'h00);
        if (par_mode && ok) n.ctl = put(put(r.ctl, r.ad, r.d0), r.ad + 16'h1, r.d1);
        case (r.seq)
          3'h0: hit = r.ad == `REG_KEY && r.d0 == `SEQ1_D0;
          3'h1: hit = r.ad == `REG_CONTROL && r.d0 == `SEQ2_D0;
          3'h2: hit = r.ad == `REG_RATE;
          3'h3: hit = r.ad == `REG_ARM && r.d0 == 8'h00;
          default: hit = r.ad == `REG_KEY && r.d0 == 8'h00;
        endcase
        hit = ok && hit && r.d1 == 8'h00;
        if (hit && r.seq == 3'h2) n.cap_pend = r.d0;
        if (hit && r.seq == 3'h4) begin
          n.seq = 3'h0;
          n.cap = r.cap_pend;
          n.ctl = `CTL_RST;
        end else if (hit) begin
          n.seq = r.seq + 3'h1;
        end else begin
          n.seq = (ok && r.ad == `REG_KEY && r.d0 == `SEQ1_D0 && r.d1 == 8'h00) ? 3'h1 : 3'h0;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      r     <= '0;
      r.st  <= S_IDLE;
      r.rdy <= 1'b1;
      r.ctl <= `CTL_RST;
      r.cap <= `CAP_RST;
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign scl_o            = 1'b0;
  assign sda_o            = 1'b0;
  assign scl_oe           = r.scl_oe;
  assign sda_oe           = r.sda_oe;
  assign ready            = r.rdy;
  assign radio_enable     = r.ctl[`CTL_RADIO];
  assign rate_cap         = r.cap;
  // selection is never refused on rate grounds
  assign high_rate_answer = 1'b1;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  localparam int RDY_N = 40;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence ready_back;
    !ready ##[0:RDY_N] ready;
  endsequence

  a_ready_drop: assert property (start_ev |=> !ready)
    else $error("ready stayed high after start");
  a_ready_rise: assert property ((stop_ev && !ready && !start_ev) |=> ready_back)
    else $error("ready did not return after stop");
  a_stretch_hold: assert property ($rose(r.st == S_PREP) |-> r.scl_oe [*8])
    else $error("clock not held during read preparation");
  a_addr_match: assert property ((r.st == S_ACK && r.idx == 3'h1)
    |-> r.sh[7:1] == {`TGT_ADDR_HI, r.filt[4:2]})
    else $error("acknowledged a foreign address");
  a_parity_drop: assert property ((stop_ev && par_mode && !r.rd && r.par != 8'h00)
    |=> $stable(r.ctl))
    else $error("write with bad parity committed");
  a_seq_clear: assert property ($changed(r.cap)
    |-> r.ctl == 16'h0 && $past(r.seq) == 3'h4)
    else $error("capability changed without control clear");
  a_ptr_step: assert property ((r.st == S_ACK && $past(r.st) == S_RXB && r.idx > 3'h3
    && !$past(par_mode)) |-> r.ptr == $past(r.ptr) + 16'h1)
    else $error("address did not advance by one");
  a_no_commit: assert property ((par_mode && !stop_ev) |=> $stable(r.ctl))
    else $error("parity mode write before stop");

endmodule // tag_host_serial_port
`default_nettype wire

// ===== tag_host_serial_port_bench.sv
// Purpose: self-checking bench of the host serial port
// Assumes: host model drives the bus, lines pulled up
// Notes:   parity mode goes last, it changes all framing
`default_nettype none
module tag_host_serial_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic        wr;
    logic [15:0] a;
    logic [15:0] d;
    logic [15:0] e;
    logic        rad;
  } row_t;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [2:0]  sel = 3'h0;
  logic [6:0]  tgt = 7'h18;
  logic        scl_w, sda_w, scl_m, sda_m, scl_oe, sda_oe;
  logic        ready, radio_enable, high_rate_answer;
  logic        stretched = 1'b0;
  logic [7:0]  rate_cap;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  row_t        rows [4] = '{'{1'b0, 16'hFFFC, 16'h0000, 16'h0001, 1'b0},
                            '{1'b1, 16'hFFFE, 16'h0016, 16'h0016, 1'b1},
                            '{1'b1, 16'h1234, 16'hABCD, 16'h0000, 1'b1},
                            '{1'b1, 16'hFFFE, 16'h0000, 16'h0000, 1'b0}};
  logic [31:0] seq [5] = '{32'hFFE04E00, 32'hFFFE8000, 32'h2ABAF700,
                           32'h27B80000, 32'hFFE00000};
  assign scl_w = ~scl_oe & scl_m;
  assign sda_w = ~sda_oe & sda_m;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (scl_oe === 1'b1) stretched <= 1'b1;
  host_model host (.mclk(mclk), .scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));
  tag_host_serial_port dut (
    .mclk(mclk), .rstn(rstn), .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe), .addr_select_bit0(sel[0]),
    .addr_select_bit1(sel[1]), .addr_select_bit2(sel[2]), .ready(ready),
    .radio_enable(radio_enable), .rate_cap(rate_cap),
    .high_rate_answer(high_rate_answer));
  // ------------------------------------------------------------
  // shared bus tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic logic [7:0] parity_of(input logic [15:0] a, input logic [15:0] d);
    return a[15:8] ^ a[7:0] ^ d[15:8] ^ d[7:0];
  endfunction
  task automatic put(input logic [7:0] b, input logic ea);
    logic [7:0] rx;
    logic       a;
    host.xfer(b, 1'b1, rx, a);
    chk("ack", {15'h0, ea}, {15'h0, a});
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 80) begin
      @(negedge mclk);
      k++;
    end
    chk("ready idle", 16'h1, {15'h0, ready});
  endtask
  task automatic open_x(input logic [15:0] a);
    wait_ready();
    host.start();
    chk("ready busy", 16'h0, {15'h0, ready});
    put({tgt, 1'b0}, 1'b1);
    put(a[15:8], 1'b1);
    put(a[7:0], 1'b1);
  endtask
  task automatic close_x();
    host.stop();
    repeat (20) @(negedge mclk);
    chk("ready after stop", 16'h0, {15'h0, ready});
    wait_ready();
  endtask
  task automatic wr16(input logic [15:0] a, input logic [15:0] d, input logic par,
                      input logic bad);
    open_x(a);
    put(d[15:8], 1'b1);
    put(d[7:0], 1'b1);
    if (par) put(parity_of(a, d) ^ {7'h0, bad}, 1'b1);
    close_x();
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic par, input logic [15:0] e);
    logic [7:0] d0, d1, p;
    logic       k;
    open_x(a);
    host.start();
    put({tgt, 1'b1}, 1'b1);
    host.xfer(8'hFF, 1'b0, d0, k);
    host.xfer(8'hFF, !par, d1, k);
    if (par) host.xfer(8'hFF, 1'b1, p, k);
    close_x();
    chk("read data", e, {d0, d1});
    if (par) chk("read parity", {8'h0, parity_of(a, e)}, {8'h0, p});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge mclk);
    n_mismatch++;
    wrap_up();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(negedge mclk);
    chk("reset state", 16'h0800, {4'h0, ready, scl_oe, sda_oe, radio_enable,
                                  rate_cap});
    rstn = 1'b1;
    repeat (10) @(negedge mclk);
    $display("reset test done");
    foreach (rows[i]) begin
      if (rows[i].wr) wr16(rows[i].a, rows[i].d, 1'b0, 1'b0);
      rd_chk(rows[i].a, 1'b0, rows[i].e);
      chk("radio_enable", {15'h0, rows[i].rad}, {15'h0, radio_enable});
      $display("row %0d done", i);
    end
    chk("clock stretch", 16'h1, {15'h0, stretched});
    sel = 3'h1;
    // selects must clear the pin synchroniser before the next address byte
    repeat (10) @(negedge mclk);
    $display("select test started");
    tgt = 7'h18;
    wait_ready();
    host.start();
    put(8'h30, 1'b0);
    close_x();
    tgt = 7'h19;
    rd_chk(16'hFFFC, 1'b0, 16'h0001);
    sel = 3'h0;
    tgt = 7'h18;
    repeat (10) @(negedge mclk);
    $display("select test done");
    foreach (seq[i]) wr16(seq[i][31:16], seq[i][15:0], 1'b0, 1'b0);
    chk("rate_cap", 16'h00F7, {8'h0, rate_cap});
    chk("high_rate_answer", 16'h1, {15'h0, high_rate_answer});
    rd_chk(16'hFFFE, 1'b0, 16'h0000);
    $display("rate test done");
    wr16(16'hFFFE, 16'h1000, 1'b0, 1'b0);
    wr16(16'hFFFE, 16'h1002, 1'b1, 1'b0);
    chk("radio_enable", 16'h1, {15'h0, radio_enable});
    wr16(16'hFFFE, 16'h1000, 1'b1, 1'b1);
    chk("radio_enable", 16'h1, {15'h0, radio_enable});
    rd_chk(16'hFFFE, 1'b1, 16'h1002);
    chk("clock waits", 16'h0, host.stalls[15:0]);
    $display("parity test done");
    wrap_up();
  end
endmodule // tag_host_serial_port_bench
`default_nettype wire

// ===== tag_pkg.sv
// Purpose: types of the host serial port
// Assumes: nothing
// Notes:   all state of the port is one packed struct
`default_nettype none
package tag_pkg;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_RXB  = 6'h02,
    S_ACK  = 6'h04,
    S_PREP = 6'h08,
    S_TXB  = 6'h10,
    S_RACK = 6'h20
  } phase_t;

  typedef struct packed {
    logic [4:0]  s1, s2, s3, filt;
    logic [1:0]  pv;
    phase_t      st;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic [2:0]  idx;
    logic        rd, ack, up, rdy, sda_oe, scl_oe;
    logic [15:0] ptr, ad, ctl;
    logic [7:0]  d0, d1, par, cnt, dly, cap, cap_pend;
    logic [2:0]  seq;
  } port_state_t;
endpackage
`default_nettype wire
